// File: include/cuc_pkg.sv
// Constants and types for the unary, compare and interrupt-control executor.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
package cuc_pkg;
   // Opcodes of the instruction group.
   localparam logic [7:0] OPC_CLR_R    = 8'hB0;
   localparam logic [7:0] OPC_CLR_IR   = 8'hB1;
   localparam logic [7:0] OPC_COM_R    = 8'h60;
   localparam logic [7:0] OPC_COM_IR   = 8'h61;
   localparam logic [7:0] OPC_CP_WW    = 8'hA2;
   localparam logic [7:0] OPC_CP_WIW   = 8'hA3;
   localparam logic [7:0] OPC_CP_RR    = 8'hA4;
   localparam logic [7:0] OPC_CP_RIR   = 8'hA5;
   localparam logic [7:0] OPC_CP_RIM   = 8'hA6;
   localparam logic [7:0] OPC_DEC_R    = 8'h00;
   localparam logic [7:0] OPC_DEC_IR   = 8'h01;
   localparam logic [7:0] OPC_INC_R    = 8'h20;
   localparam logic [7:0] OPC_INC_IR   = 8'h21;
   localparam logic [3:0] OPC_INC_WLO  = 4'hE;
   localparam logic [7:0] OPC_MASK     = 8'h8F;
   localparam logic [7:0] OPC_UNMASK   = 8'h9F;
   localparam logic [7:0] OPC_HALT     = 8'h6F;
   // Register space.
   localparam logic [7:0] ADR_FLAGS    = 8'hD5;
   localparam logic [7:0] ADR_SYM      = 8'hDE;
   localparam logic [3:0] WRK_BASE_HI  = 4'hC;
   localparam int         SYM_GIE      = 2;
   localparam int         FLG_C        = 7;
   localparam int         FLG_Z        = 6;
   localparam int         FLG_S        = 5;
   localparam int         FLG_V        = 4;
   localparam logic [7:0] VAL_MIN_NEG  = 8'h80;
   localparam logic [7:0] VAL_MAX_POS  = 8'h7F;
   // Instruction lengths in cycles.
   localparam logic [2:0] CYC_SHORT    = 3'h4;
   localparam logic [2:0] CYC_LONG     = 3'h6;
   localparam logic [2:0] CYC_CNT_OFS  = 3'h2;
   // Bus map beyond the register space.
   localparam logic [11:0] AXA_PEND    = 12'h400;
   localparam logic [11:0] AXA_STAT    = 12'h404;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum {ST_WAIT, ST_EXEC, ST_HALT} cuc_state_t;
   typedef enum {CL_NOP, CL_CLR, CL_COM, CL_CP, CL_DEC, CL_INC,
                 CL_MASK, CL_UNMASK, CL_HALT} cuc_class_t;
endpackage : cuc_pkg

// File: src/cuc_core.sv
// Executor for clear, complement, compare, decrement, increment, global
// interrupt mask/unmask and clock halt, with its own register space.
// Assumes instructions arrive one at a time on a valid/ready port and that
// software reaches the register space over AXI4-Lite on the same clock.
`timescale 1ns/10ps

// Notes on behaviour
// - clear writes zero, flags untouched, four cycles
// - pointer mode addresses via register content only
// - complement inverts every destination bit
// - complement sets Z,S, clears V, keeps C
// - compare changes only flags; 4 or 6 cycles
// - compare C on borrow, Z zero, S negative
// - compare V when signs differ, result like source
// - decrement subtracts one, keeps C, sets Z,S
// - decrement V only from 80H to 7FH
// - increment adds one, three forms, keeps C
// - increment V only from 7FH to 80H
// - mask clears mode bit 2, flags untouched
// - masked requests still latch their pending bits
// - unmask sets mode bit 2, flags untouched
// - held pending requests served after unmask
// - mode bit 2 is global enable, 04H/00H
// - halt stops CPU clock, system clock runs
// - request or reset leaves the halted state
// - flags live at register address 0D5H
module cuc_core #(
   parameter int N_IRQ = 8
) (
   // Clock and reset
   input  wire logic              CLK_I,
   input  wire logic              RST_N_I,
   // Instruction port
   input  wire logic              INSTR_VALID_I,
   input  wire logic [7:0]        INSTR_OPC_I,
   input  wire logic [7:0]        INSTR_OP1_I,
   input  wire logic [7:0]        INSTR_OP2_I,
   output logic                   INSTR_READY_O,
   output logic                   INSTR_DONE_O,
   output logic                   CPU_CLK_EN_O,
   // Interrupt requests
   input  wire logic [N_IRQ-1:0]  IRQ_I,
   input  wire logic [N_IRQ-1:0]  INT_ACK_I,
   output logic                   INT_REQ_O,
   // AXI4-Lite slave
   input  wire logic [11:0]       S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output logic                   S_AXI_AWREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output logic                   S_AXI_WREADY_O,
   output logic [1:0]             S_AXI_BRESP_O,
   output logic                   S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   input  wire logic [11:0]       S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output logic                   S_AXI_ARREADY_O,
   output logic [31:0]            S_AXI_RDATA_O,
   output logic [1:0]             S_AXI_RRESP_O,
   output logic                   S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I
);
   logic [7:0]          rf [256];
   cuc_pkg::cuc_state_t st;
   cuc_pkg::cuc_state_t next_st;
   cuc_pkg::cuc_class_t cls;
   cuc_pkg::cuc_class_t next_cls;
   logic [2:0]          cnt;
   logic [2:0]          next_cyc;
   logic [7:0]          dst_a;
   logic [7:0]          next_dst;
   logic [7:0]          src_v;
   logic [7:0]          next_src;
   logic [N_IRQ-1:0]    pend;
   logic                acc;
   logic                cmpl;
   logic [7:0]          dval;
   logic [7:0]          res;
   logic [8:0]          diff;
   logic [7:0]          next_flags;
   logic                dst_wr;
   logic                wr_rdy;
   logic                rd_rdy;
   logic                gie;

   // Ready gates acceptance too, so nothing is taken in the cycle after reset.
   assign acc  = (st == cuc_pkg::ST_WAIT) && INSTR_READY_O && INSTR_VALID_I;
   assign cmpl = (st == cuc_pkg::ST_EXEC) && (cnt == 3'h0);
   assign gie  = rf[cuc_pkg::ADR_SYM][cuc_pkg::SYM_GIE];
   assign dval = rf[dst_a];

   // Decode at acceptance; pointers are dereferenced here and never written.
   always_comb
   begin
      next_cls = cuc_pkg::CL_NOP;
      next_cyc = cuc_pkg::CYC_SHORT;
      next_dst = INSTR_OP1_I;
      next_src = 8'h00;
      unique case (INSTR_OPC_I)
         cuc_pkg::OPC_CLR_R, cuc_pkg::OPC_CLR_IR:
         begin
            next_cls = cuc_pkg::CL_CLR;
            if (INSTR_OPC_I[0])
               next_dst = rf[INSTR_OP1_I];
         end
         cuc_pkg::OPC_COM_R, cuc_pkg::OPC_COM_IR:
         begin
            next_cls = cuc_pkg::CL_COM;
            if (INSTR_OPC_I[0])
               next_dst = rf[INSTR_OP1_I];
         end
         cuc_pkg::OPC_DEC_R, cuc_pkg::OPC_DEC_IR:
         begin
            next_cls = cuc_pkg::CL_DEC;
            if (INSTR_OPC_I[0])
               next_dst = rf[INSTR_OP1_I];
         end
         cuc_pkg::OPC_INC_R, cuc_pkg::OPC_INC_IR:
         begin
            next_cls = cuc_pkg::CL_INC;
            if (INSTR_OPC_I[0])
               next_dst = rf[INSTR_OP1_I];
         end
         cuc_pkg::OPC_CP_WW:
         begin
            next_cls = cuc_pkg::CL_CP;
            next_dst = {cuc_pkg::WRK_BASE_HI, INSTR_OP1_I[7:4]};
            next_src = rf[{cuc_pkg::WRK_BASE_HI, INSTR_OP1_I[3:0]}];
         end
         cuc_pkg::OPC_CP_WIW:
         begin
            next_cls = cuc_pkg::CL_CP;
            next_cyc = cuc_pkg::CYC_LONG;
            next_dst = {cuc_pkg::WRK_BASE_HI, INSTR_OP1_I[7:4]};
            next_src = rf[rf[{cuc_pkg::WRK_BASE_HI, INSTR_OP1_I[3:0]}]];
         end
         cuc_pkg::OPC_CP_RR, cuc_pkg::OPC_CP_RIR:
         begin
            next_cls = cuc_pkg::CL_CP;
            next_cyc = cuc_pkg::CYC_LONG;
            next_dst = INSTR_OP2_I;
            next_src = INSTR_OPC_I[0] ? rf[rf[INSTR_OP1_I]] : rf[INSTR_OP1_I];
         end
         cuc_pkg::OPC_CP_RIM:
         begin
            next_cls = cuc_pkg::CL_CP;
            next_cyc = cuc_pkg::CYC_LONG;
            next_src = INSTR_OP2_I;
         end
         cuc_pkg::OPC_MASK:   next_cls = cuc_pkg::CL_MASK;
         cuc_pkg::OPC_UNMASK: next_cls = cuc_pkg::CL_UNMASK;
         cuc_pkg::OPC_HALT:   next_cls = cuc_pkg::CL_HALT;
         default:
         begin
            // Unknown opcodes run as four-cycle no-operations.
            if (INSTR_OPC_I[3:0] == cuc_pkg::OPC_INC_WLO)
            begin
               next_cls = cuc_pkg::CL_INC;
               next_dst = {cuc_pkg::WRK_BASE_HI, INSTR_OPC_I[7:4]};
            end
         end
      endcase
   end

   // Result and flags, both applied on the completion edge.
   always_comb
   begin
      res        = dval;
      diff       = {1'b0, dval} - {1'b0, src_v};
      next_flags = rf[cuc_pkg::ADR_FLAGS];
      dst_wr     = 1'b0;
      unique case (cls)
         cuc_pkg::CL_CLR:
         begin
            res    = 8'h00;
            dst_wr = 1'b1;
         end
         cuc_pkg::CL_COM:
         begin
            res    = ~dval;
            dst_wr = 1'b1;
            next_flags[cuc_pkg::FLG_V] = 1'b0;
         end
         cuc_pkg::CL_DEC:
         begin
            res    = dval - 8'h01;
            dst_wr = 1'b1;
            next_flags[cuc_pkg::FLG_V] = (dval == cuc_pkg::VAL_MIN_NEG);
         end
         cuc_pkg::CL_INC:
         begin
            res    = dval + 8'h01;
            dst_wr = 1'b1;
            next_flags[cuc_pkg::FLG_V] = (dval == cuc_pkg::VAL_MAX_POS);
         end
         cuc_pkg::CL_CP:
         begin
            res = diff[7:0];
            next_flags[cuc_pkg::FLG_C] = diff[8];
            next_flags[cuc_pkg::FLG_V] = (dval[7] ^ src_v[7])
                                       & (diff[7] == src_v[7]);
         end
         default:
         begin
         end
      endcase
      if ((cls == cuc_pkg::CL_COM) || (cls == cuc_pkg::CL_DEC)
          || (cls == cuc_pkg::CL_INC) || (cls == cuc_pkg::CL_CP))
      begin
         next_flags[cuc_pkg::FLG_Z] = (res == 8'h00);
         next_flags[cuc_pkg::FLG_S] = res[7];
      end
   end

   // Sequencer.
   always_comb
   begin
      next_st = st;
      unique case (st)
         cuc_pkg::ST_WAIT:
            if (acc)
               next_st = cuc_pkg::ST_EXEC;
         cuc_pkg::ST_EXEC:
            if (cnt == 3'h0)
               next_st = (cls == cuc_pkg::CL_HALT) ? cuc_pkg::ST_HALT
                                                   : cuc_pkg::ST_WAIT;
         cuc_pkg::ST_HALT:
            if (|IRQ_I)
               next_st = cuc_pkg::ST_WAIT;
      endcase
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         st            <= cuc_pkg::ST_WAIT;
         cnt           <= 3'h0;
         cls           <= cuc_pkg::CL_NOP;
         dst_a         <= 8'h00;
         src_v         <= 8'h00;
         INSTR_READY_O <= 1'b0;
         INSTR_DONE_O  <= 1'b0;
         CPU_CLK_EN_O  <= 1'b1;
      end
      else
      begin
         st            <= next_st;
         INSTR_READY_O <= (next_st == cuc_pkg::ST_WAIT);
         INSTR_DONE_O  <= cmpl;
         CPU_CLK_EN_O  <= (next_st != cuc_pkg::ST_HALT);
         if (acc)
         begin
            cls   <= next_cls;
            dst_a <= next_dst;
            src_v <= next_src;
            cnt   <= next_cyc - cuc_pkg::CYC_CNT_OFS;
         end
         else if (st == cuc_pkg::ST_EXEC)
            cnt <= cnt - 3'h1;
      end
   end

   // Register space: bus write first, then the executor, which wins a clash.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         rf[cuc_pkg::ADR_FLAGS] <= 8'h00;
         rf[cuc_pkg::ADR_SYM]   <= 8'h00;
      end
      else
      begin
         if (S_AXI_AWVALID_I && S_AXI_WVALID_I && wr_rdy && S_AXI_WSTRB_I[0]
             && (S_AXI_AWADDR_I < cuc_pkg::AXA_PEND))
            rf[S_AXI_AWADDR_I[9:2]] <= S_AXI_WDATA_I[7:0];
         if (cmpl)
         begin
            rf[cuc_pkg::ADR_FLAGS] <= next_flags;
            if (cls == cuc_pkg::CL_MASK)
               rf[cuc_pkg::ADR_SYM][cuc_pkg::SYM_GIE] <= 1'b0;
            if (cls == cuc_pkg::CL_UNMASK)
               rf[cuc_pkg::ADR_SYM][cuc_pkg::SYM_GIE] <= 1'b1;
            if (dst_wr)
               rf[dst_a] <= res;
         end
      end
   end

   // Pending bits latch regardless of the global enable; a new request wins.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         pend      <= '0;
         INT_REQ_O <= 1'b0;
      end
      else
      begin
         pend      <= (pend & ~INT_ACK_I) | IRQ_I;
         INT_REQ_O <= gie & (|pend);
      end
   end

   // AXI4-Lite write channel; address and data are taken together.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         wr_rdy         <= 1'b0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= cuc_pkg::RESP_OKAY;
      end
      else if (S_AXI_BVALID_O)
      begin
         if (S_AXI_BREADY_I)
         begin
            S_AXI_BVALID_O <= 1'b0;
            wr_rdy         <= 1'b1;
         end
      end
      else if (S_AXI_AWVALID_I && S_AXI_WVALID_I && wr_rdy)
      begin
         wr_rdy         <= 1'b0;
         S_AXI_BVALID_O <= 1'b1;
         S_AXI_BRESP_O  <= (S_AXI_AWADDR_I < cuc_pkg::AXA_PEND)
                         ? cuc_pkg::RESP_OKAY : cuc_pkg::RESP_SLVERR;
      end
      else
         wr_rdy <= 1'b1;
   end
   assign S_AXI_AWREADY_O = wr_rdy;
   assign S_AXI_WREADY_O  = wr_rdy;

   // AXI4-Lite read channel.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         rd_rdy         <= 1'b0;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O  <= 32'h0000_0000;
         S_AXI_RRESP_O  <= cuc_pkg::RESP_OKAY;
      end
      else if (S_AXI_RVALID_O)
      begin
         if (S_AXI_RREADY_I)
         begin
            S_AXI_RVALID_O <= 1'b0;
            rd_rdy         <= 1'b1;
         end
      end
      else if (S_AXI_ARVALID_I && rd_rdy)
      begin
         rd_rdy         <= 1'b0;
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RRESP_O  <= cuc_pkg::RESP_OKAY;
         S_AXI_RDATA_O  <= 32'h0000_0000;
         if (S_AXI_ARADDR_I < cuc_pkg::AXA_PEND)
            S_AXI_RDATA_O[7:0] <= rf[S_AXI_ARADDR_I[9:2]];
         else if (S_AXI_ARADDR_I == cuc_pkg::AXA_PEND)
            S_AXI_RDATA_O[N_IRQ-1:0] <= pend;
         else if (S_AXI_ARADDR_I == cuc_pkg::AXA_STAT)
            S_AXI_RDATA_O[1:0] <= {st == cuc_pkg::ST_HALT, st == cuc_pkg::ST_EXEC};
         else
            S_AXI_RRESP_O <= cuc_pkg::RESP_SLVERR;
      end
      else
         rd_rdy <= 1'b1;
   end
   assign S_AXI_ARREADY_O = rd_rdy;

   // Checks.
   logic dst_plain;
   assign dst_plain = (dst_a != cuc_pkg::ADR_FLAGS) && (dst_a != cuc_pkg::ADR_SYM);

   sequence seq_acc_short;
      acc && (next_cyc == cuc_pkg::CYC_SHORT);
   endsequence
   sequence seq_acc_long;
      acc && (next_cyc == cuc_pkg::CYC_LONG);
   endsequence

   AST_CLR_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_CLR) && dst_plain
      |=> (rf[$past(dst_a)] == 8'h00) && $stable(rf[cuc_pkg::ADR_FLAGS]))
      else $error("Clear did not zero destination or touched flags.");
   AST_SHORT_CYC: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      seq_acc_short |=> !INSTR_DONE_O [*3] ##1 INSTR_DONE_O)
      else $error("Short instruction did not take four cycles.");
   AST_LONG_CYC: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      seq_acc_long |=> !INSTR_DONE_O [*5] ##1 INSTR_DONE_O)
      else $error("Long compare did not take six cycles.");
   AST_COM_FLAGS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_COM) && dst_plain
      |=> !rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_V]
          && (rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_C]
              == $past(rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_C]))
          && (rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_Z] == ($past(dval) == 8'hFF)))
      else $error("Complement flags wrong.");
   AST_CP_CARRY: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_CP) && dst_plain
      |=> (rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_C] == ($past(src_v) > $past(dval)))
          && (rf[$past(dst_a)] == $past(dval)))
      else $error("Compare carry wrong or operand changed.");
   AST_CP_OVF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_CP) && (dval == 8'h80) && (src_v == 8'h01)
      |=> rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_V])
      else $error("Compare overflow missed.");
   AST_DEC_OVF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_DEC) && dst_plain
      |=> rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_V] == ($past(dval) == 8'h80))
      else $error("Decrement overflow wrong.");
   AST_INC_OVF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_INC) && dst_plain
      |=> rf[cuc_pkg::ADR_FLAGS][cuc_pkg::FLG_V] == ($past(dval) == 8'h7F))
      else $error("Increment overflow wrong.");
   AST_MASK_REQ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      INT_REQ_O |-> $past(gie) && ($past(pend) != '0))
      else $error("Interrupt raised while masked or nothing pending.");
   AST_HALT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cmpl && (cls == cuc_pkg::CL_HALT) |=> !CPU_CLK_EN_O)
      else $error("Halt did not stop the CPU clock.");
   AST_WAKE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (st == cuc_pkg::ST_HALT) && (|IRQ_I) |=> CPU_CLK_EN_O && INSTR_READY_O)
      else $error("Request did not release halt.");
endmodule : cuc_core

// File: test/cuc_irq_src.sv
// Interrupt source model for the peripherals that sit outside the executor.
// Assumes the bench asks for a request by strobing fire_i for one cycle.
`timescale 1ns/10ps
module cuc_irq_src #(
   parameter int N_IRQ = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Bench control
   input  wire logic             fire_i,
   input  wire logic [2:0]       src_i,
   input  wire logic             ack_en_i,
   // Executor side
   input  wire logic             int_req_i,
   output logic      [N_IRQ-1:0] irq_o,
   output logic      [N_IRQ-1:0] ack_o
);
   logic [2:0] last_src;

   // A request is a one-cycle strobe, so only the pending latch can keep it alive.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         irq_o <= '0;
      else
         irq_o <= fire_i ? (N_IRQ'(1) << src_i) : '0;
   end

   always_ff @(posedge clk_i)
   begin
      if (fire_i)
         last_src <= src_i;
   end

   // Service is slow or prompt as the bench enables it; it acknowledges the last source only.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ack_o <= '0;
      else
         ack_o <= (ack_en_i && int_req_i && ack_o == '0) ? (N_IRQ'(1) << last_src) : '0;
   end
endmodule : cuc_irq_src

// File: test/cuc_core_tb_top.sv
// Self-checking bench for the unary, compare and interrupt-control executor.
// Assumes cuc_pkg and cuc_irq_src are compiled first; registers are reached over AXI4-Lite.
`timescale 1ns/10ps
module cuc_core_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        iv = 1'b0;
   logic [7:0]  opc = 8'h00, op1 = 8'h00, op2 = 8'h00;
   logic        rdy, done, cken, ireq, awr, wrdy, bv, arr, rv;
   logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0000_0000, rdat;
   logic [1:0]  bresp, rresp;
   logic [7:0]  irq, ack;
   logic        fire = 1'b0, ack_en = 1'b0;
   logic [2:0]  src = 3'h0;
   int          err_count = 0;
   int          n_compared = 0;
   int          cnt = 0;
   int          seed = 32'hae18_65f8;
   int          q_cyc[$];
   logic [1:0]  q_b[$];
   logic [33:0] q_r[$];
   logic [7:0]  vals[5] = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'h01};
   logic [7:0]  ops[8] = '{cuc_pkg::OPC_CLR_R, cuc_pkg::OPC_CLR_IR, cuc_pkg::OPC_COM_R,
      cuc_pkg::OPC_COM_IR, cuc_pkg::OPC_DEC_R, cuc_pkg::OPC_DEC_IR, cuc_pkg::OPC_INC_R,
      cuc_pkg::OPC_INC_IR};
   logic [7:0]  cmps[5] = '{cuc_pkg::OPC_CP_WW, cuc_pkg::OPC_CP_WIW, cuc_pkg::OPC_CP_RR,
      cuc_pkg::OPC_CP_RIR, cuc_pkg::OPC_CP_RIM};

   cuc_core #(.N_IRQ(8)) i_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(iv), .INSTR_OPC_I(opc),
      .INSTR_OP1_I(op1), .INSTR_OP2_I(op2), .INSTR_READY_O(rdy), .INSTR_DONE_O(done),
      .CPU_CLK_EN_O(cken), .IRQ_I(irq), .INT_ACK_I(ack), .INT_REQ_O(ireq),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr));

   cuc_irq_src #(.N_IRQ(8)) i_src (
      .clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .src_i(src), .ack_en_i(ack_en),
      .int_req_i(ireq), .irq_o(irq), .ack_o(ack));

   always #2.5 clk = ~clk;

   task automatic check(input string what, input logic [33:0] e, input logic [33:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic cmp_cyc(input int e, input int g);
      check("cycles", 34'(e), 34'(g));
   endtask : cmp_cyc

   task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
      check("bresp", 34'(e), 34'(g));
   endtask : cmp_resp

   task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
      check("rresp_rdata", e, g);
   endtask : cmp_rd

   task automatic cmp_lvl(input string what, input logic e, input logic g);
      check(what, 34'(e), 34'(g));
   endtask : cmp_lvl

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   function automatic logic [11:0] ra(input logic [7:0] r);
      ra = {2'b00, r, 2'b00};
   endfunction : ra

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
      q_b.push_back(e);
      awa <= a;
      wd <= {24'h00_0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      do @(posedge clk); while (awr !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      br <= 1'b1;
      do @(posedge clk); while (bv !== 1'b1);
      br <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
      q_r.push_back({e, 24'h00_0000, d});
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      rr <= 1'b1;
      do @(posedge clk); while (rv !== 1'b1);
      rr <= 1'b0;
   endtask : rd

   task automatic ex(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b, input int n);
      q_cyc.push_back(n);
      opc <= o;
      op1 <= a;
      op2 <= b;
      iv <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      iv <= 1'b0;
      do @(posedge clk); while (done !== 1'b1);
   endtask : ex

   task automatic pulse(input logic [2:0] s);
      src <= s;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask : pulse

   // Pointer register 20h always holds 10h, so pointer forms land on the same target.
   task automatic unary(input logic [7:0] o, input logic [7:0] v);
      logic       wk;
      logic [7:0] t, r, f0, f;
      wk = (o[3:0] == cuc_pkg::OPC_INC_WLO);
      t  = wk ? {cuc_pkg::WRK_BASE_HI, o[7:4]} : 8'h10;
      f0 = 8'($random(seed)) & 8'hF0;
      r  = v + 8'h01;
      f  = {f0[7], r == 8'h00, r[7], v == 8'h7F && r == 8'h80, 4'h0};
      if (o == cuc_pkg::OPC_CLR_R || o == cuc_pkg::OPC_CLR_IR)
      begin
         r = 8'h00;
         f = f0;
      end
      else if (o == cuc_pkg::OPC_COM_R || o == cuc_pkg::OPC_COM_IR)
      begin
         r = ~v;
         f = {f0[7], r == 8'h00, r[7], 1'b0, 4'h0};
      end
      else if (o == cuc_pkg::OPC_DEC_R || o == cuc_pkg::OPC_DEC_IR)
      begin
         r = v - 8'h01;
         f = {f0[7], r == 8'h00, r[7], v == 8'h80 && r == 8'h7F, 4'h0};
      end
      wr(ra(8'h20), 8'h10, cuc_pkg::RESP_OKAY);
      wr(ra(t), v, cuc_pkg::RESP_OKAY);
      wr(ra(cuc_pkg::ADR_FLAGS), f0, cuc_pkg::RESP_OKAY);
      ex(o, (!wk && o[0]) ? 8'h20 : t, 8'h00, 4);
      rd(ra(t), r, cuc_pkg::RESP_OKAY);
      rd(ra(cuc_pkg::ADR_FLAGS), f, cuc_pkg::RESP_OKAY);
      rd(ra(8'h20), 8'h10, cuc_pkg::RESP_OKAY);
   endtask : unary

   task automatic compare_op(input logic [7:0] o, input logic [7:0] dv, input logic [7:0] sv);
      logic [7:0] df, a;
      df = dv - sv;
      a  = (o == cuc_pkg::OPC_CP_RR) ? 8'h31 : (o == cuc_pkg::OPC_CP_RIR) ? 8'h33 : 8'h35;
      wr(ra(8'hC3), dv, cuc_pkg::RESP_OKAY);
      wr(ra(8'h32), dv, cuc_pkg::RESP_OKAY);
      wr(ra(8'hC5), (o == cuc_pkg::OPC_CP_WIW) ? 8'h30 : sv, cuc_pkg::RESP_OKAY);
      wr(ra(8'h30), sv, cuc_pkg::RESP_OKAY);
      wr(ra(8'h31), sv, cuc_pkg::RESP_OKAY);
      wr(ra(8'h33), 8'h31, cuc_pkg::RESP_OKAY);
      if (o == cuc_pkg::OPC_CP_RIM)
         ex(o, 8'h32, sv, 6);
      else
         ex(o, a, 8'h32, (o == cuc_pkg::OPC_CP_WW) ? 4 : 6);
      rd(ra(cuc_pkg::ADR_FLAGS), {sv > dv, df == 8'h00, df[7],
         (dv[7] != sv[7]) && (df[7] == sv[7]), 4'h0}, cuc_pkg::RESP_OKAY);
      rd(ra(8'hC3), dv, cuc_pkg::RESP_OKAY);
      rd(ra(8'h32), dv, cuc_pkg::RESP_OKAY);
      rd(ra(8'h30), sv, cuc_pkg::RESP_OKAY);
   endtask : compare_op

   // Results are matched against the oldest note whenever they show at the ports.
   always @(posedge clk)
   begin
      if (done === 1'b1 && q_cyc.size() > 0)
         cmp_cyc(q_cyc.pop_front(), cnt + 1);
      cnt <= (iv && rdy === 1'b1) ? 0 : cnt + 1;
      if (bv === 1'b1 && br && q_b.size() > 0)
         cmp_resp(q_b.pop_front(), bresp);
      if (rv === 1'b1 && rr && q_r.size() > 0)
         cmp_rd(q_r.pop_front(), {rresp, rdat});
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(ra(cuc_pkg::ADR_FLAGS), 8'h00, cuc_pkg::RESP_OKAY);
      rd(ra(cuc_pkg::ADR_SYM), 8'h00, cuc_pkg::RESP_OKAY);
      rd(12'h408, 8'h00, cuc_pkg::RESP_SLVERR);
      wr(cuc_pkg::AXA_PEND, 8'hFF, cuc_pkg::RESP_SLVERR);
      foreach (ops[i])
         for (int k = 0; k < 6; k++)
            unary(ops[i], (k == 5) ? 8'($random(seed)) : vals[k]);
      for (int n = 0; n < 16; n++)
         unary({4'(n), cuc_pkg::OPC_INC_WLO}, vals[n % 5]);
      foreach (cmps[i])
         for (int k = 0; k < 17; k++)
            compare_op(cmps[i], (k == 16) ? 8'($random(seed)) : vals[k / 4],
               (k == 16) ? 8'($random(seed)) : vals[k % 4]);
      wr(ra(cuc_pkg::ADR_FLAGS), 8'hA0, cuc_pkg::RESP_OKAY);
      ex(cuc_pkg::OPC_UNMASK, 8'h00, 8'h00, 4);
      rd(ra(cuc_pkg::ADR_SYM), 8'h04, cuc_pkg::RESP_OKAY);
      ex(cuc_pkg::OPC_MASK, 8'h00, 8'h00, 4);
      rd(ra(cuc_pkg::ADR_SYM), 8'h00, cuc_pkg::RESP_OKAY);
      pulse(3'h3);
      repeat (4) @(posedge clk);
      cmp_lvl("int_req", 1'b0, ireq);
      rd(cuc_pkg::AXA_PEND, 8'h08, cuc_pkg::RESP_OKAY);
      ex(cuc_pkg::OPC_UNMASK, 8'h00, 8'h00, 4);
      repeat (2) @(posedge clk);
      cmp_lvl("int_req", 1'b1, ireq);
      ack_en <= 1'b1;
      repeat (4) @(posedge clk);
      ack_en <= 1'b0;
      repeat (3) @(posedge clk);
      cmp_lvl("int_req", 1'b0, ireq);
      rd(cuc_pkg::AXA_PEND, 8'h00, cuc_pkg::RESP_OKAY);
      ex(cuc_pkg::OPC_HALT, 8'h00, 8'h00, 4);
      cmp_lvl("cpu_clk_en", 1'b0, cken);
      repeat (6) @(posedge clk);
      cmp_lvl("cpu_clk_en", 1'b0, cken);
      cmp_lvl("instr_ready", 1'b0, rdy);
      rd(cuc_pkg::AXA_STAT, 8'h02, cuc_pkg::RESP_OKAY);
      pulse(3'h1);
      repeat (3) @(posedge clk);
      cmp_lvl("cpu_clk_en", 1'b1, cken);
      ack_en <= 1'b1;
      repeat (4) @(posedge clk);
      ack_en <= 1'b0;
      rd(ra(cuc_pkg::ADR_FLAGS), 8'hA0, cuc_pkg::RESP_OKAY);
      ex(cuc_pkg::OPC_HALT, 8'h00, 8'h00, 4);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      cmp_lvl("cpu_clk_en", 1'b1, cken);
      rd(ra(cuc_pkg::ADR_SYM), 8'h00, cuc_pkg::RESP_OKAY);
      finish_test();
   end
endmodule : cuc_core_tb_top
